// ### hdl/sia_top.sv
`timescale 1ns/10ps
module sia_top
    import sia_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AXI4-Lite write address.
    input wire logic [SIA_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [SIA_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event sources.
    input wire logic [SIA_TIMERS-1:0] timer_expire_i,
    input wire logic [SIA_PINS-1:0] pin_i,
    input wire logic [SIA_PINS-1:0] pin_is_input_i,
    input wire logic [SIA_CHANS-1:0] dma_chan_irq_i,
    // Service routine entry acknowledge and exit, one pulse each.
    input wire logic timer_isr_enter_i,
    input wire logic pin_isr_enter_i,
    input wire logic dma_isr_enter_i,
    input wire logic timer_isr_exit_i,
    input wire logic pin_isr_exit_i,
    input wire logic dma_isr_exit_i,
    // Shared CPU-level flags.
    output logic [15:0] cpu_flag_word_a_o,
    output logic [15:0] cpu_flag_word_b_o
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [SIA_TIMERS-1:0] timer_irq_source_latch_q;
    logic [SIA_PINS-1:0] pin_irq_enable_q;
    logic [SIA_PINS-1:0] pin_irq_flag_q;
    logic [SIA_CHANS-1:0] channel_irq_enable_reg_q;
    logic [SIA_CHANS-1:0] channel_irq_flag_reg_q;
    logic [2:0] cpu_flag_q;
    logic [2:0] in_isr_q;
    logic [SIA_PINS-1:0] pin_lvl;
    logic [SIA_PINS-1:0] pin_prev_q;
    logic [SIA_PINS-1:0] pin_set;
    logic [2:0] group_any;
    logic [2:0] enter;
    logic [2:0] leave;

    // ----------------------------------------------------------------
    // Bus state
    // ----------------------------------------------------------------
    logic awrdy_q;
    logic wrdy_q;
    logic aw_have_q;
    logic w_have_q;
    logic [SIA_AW-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arrdy_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic commit;
    logic [15:0] wmask;
    logic [15:0] wclr;
    logic [15:0] wval;
    logic wmapped;
    logic [31:0] rd_word;
    logic rd_mapped;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    sia_pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(pin_i),
        .level_o(pin_lvl)
    );

    // Previous filtered level for rising edge detection.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_lvl;
        end
    end

    // ----------------------------------------------------------------
    // Write commit and lane decoding
    // ----------------------------------------------------------------
    assign commit = aw_have_q & w_have_q & ~bvalid_q;
    assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wval = wdata_q[15:0];
    assign wclr = wval & wmask;

    // Address check for the write in hand.
    always_comb begin
        unique case (waddr_q)
            SIA_TIMER_LATCH_OFS, SIA_PIN_EN_LO_OFS, SIA_PIN_EN_HI_OFS,
            SIA_PIN_FLG_LO_OFS, SIA_PIN_FLG_HI_OFS, SIA_CHAN_EN_OFS,
            SIA_CHAN_FLG_OFS, SIA_STATUS_OFS: wmapped = 1'h1;
            default: wmapped = 1'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Timer source latch
    // ----------------------------------------------------------------
    // per-timer latch: expiries set bits; several at once all set.
    // write-one clear, with a new expiry winning over the clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer_irq_source_latch_q <= SIA_REG_RST[SIA_TIMERS-1:0];
        end else if (commit && waddr_q == SIA_TIMER_LATCH_OFS) begin
            timer_irq_source_latch_q <= (timer_irq_source_latch_q
                & ~wclr[SIA_TIMERS-1:0]) | timer_expire_i;
        end else begin
            timer_irq_source_latch_q <= timer_irq_source_latch_q | timer_expire_i;
        end
    end

    // ----------------------------------------------------------------
    // Pin enables and flags
    // ----------------------------------------------------------------
    // Enable halves are plain read/write words under the byte strobes.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_irq_enable_q <= {SIA_REG_RST, SIA_REG_RST};
        end else if (commit && waddr_q == SIA_PIN_EN_LO_OFS) begin
            pin_irq_enable_q[15:0] <= (pin_irq_enable_q[15:0] & ~wmask) | (wval & wmask);
        end else if (commit && waddr_q == SIA_PIN_EN_HI_OFS) begin
            pin_irq_enable_q[31:16] <= (pin_irq_enable_q[31:16] & ~wmask) | (wval & wmask);
        end
    end

    // Per-pin event qualification and flag bit.
    for (genvar p = 0; p < SIA_PINS; p++) begin : g_pin
        logic clr;
        // input pins with their enable bit set only.
        assign pin_set[p] = pin_lvl[p] & ~pin_prev_q[p] & pin_is_input_i[p]
            & pin_irq_enable_q[p];
        assign clr = commit && (p < 16 ? waddr_q == SIA_PIN_FLG_LO_OFS
            : waddr_q == SIA_PIN_FLG_HI_OFS) && wclr[p % 16];
        // per-pin flag; simultaneous pins; write-one clear.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pin_irq_flag_q[p] <= 1'h0;
            end else if (pin_set[p]) begin
                pin_irq_flag_q[p] <= 1'h1;
            end else if (clr) begin
                pin_irq_flag_q[p] <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // DMA channel enables and flags
    // ----------------------------------------------------------------
    // Channel enable word, one bit per channel.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_irq_enable_reg_q <= SIA_REG_RST;
        end else if (commit && waddr_q == SIA_CHAN_EN_OFS) begin
            channel_irq_enable_reg_q <= (channel_irq_enable_reg_q & ~wmask)
                | (wval & wmask);
        end
    end

    // enabled channels only; one flag per channel.
    // write-one clear, a new event winning over the clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_irq_flag_reg_q <= SIA_REG_RST;
        end else begin
            channel_irq_flag_reg_q <= (channel_irq_flag_reg_q
                & ~((commit && waddr_q == SIA_CHAN_FLG_OFS) ? wclr : 16'h0000))
                | (dma_chan_irq_i & channel_irq_enable_reg_q);
        end
    end

    // ----------------------------------------------------------------
    // Shared CPU-level requests
    // ----------------------------------------------------------------
    // each group request is the OR of its flags.
    // all four controllers' channels fold into one DMA line.
    assign group_any[0] = |timer_irq_source_latch_q;
    assign group_any[1] = |pin_irq_flag_q;
    assign group_any[2] = |channel_irq_flag_reg_q;
    assign enter = {dma_isr_enter_i, pin_isr_enter_i, timer_isr_enter_i};
    assign leave = {dma_isr_exit_i, pin_isr_exit_i, timer_isr_exit_i};

    // Marks a group whose service routine is running.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            in_isr_q <= 3'h0;
        end else begin
            in_isr_q <= (in_isr_q & ~leave) | enter;
        end
    end

    // entry clears the flag by itself.
    // flags still set at exit raise the request again.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_flag_q <= 3'h0;
        end else begin
            cpu_flag_q <= (cpu_flag_q & ~enter)
                | (group_any & ~enter & ~(in_isr_q & ~leave));
        end
    end

    // timer at bit 4, DMA at bit 8 of word A; pins at bit 5 of word B.
    always_comb begin
        cpu_flag_word_a_o = 16'h0000;
        cpu_flag_word_b_o = 16'h0000;
        cpu_flag_word_a_o[SIA_TIMER_BIT] = cpu_flag_q[0];
        cpu_flag_word_b_o[SIA_PIN_BIT] = cpu_flag_q[1];
        cpu_flag_word_a_o[SIA_DMA_BIT] = cpu_flag_q[2];
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channels
    // ----------------------------------------------------------------
    // Address and data are taken independently and held until commit.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            awrdy_q <= 1'h0;
            aw_have_q <= 1'h0;
            waddr_q <= '0;
        end else if (s_axi_awvalid && awrdy_q) begin
            awrdy_q <= 1'h0;
            aw_have_q <= 1'h1;
            waddr_q <= {s_axi_awaddr[SIA_AW-1:2], 2'h0};
        end else begin
            if (commit) begin
                aw_have_q <= 1'h0;
            end
            awrdy_q <= ~aw_have_q & ~bvalid_q;
        end
    end

    // Write data holder.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wrdy_q <= 1'h0;
            w_have_q <= 1'h0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && wrdy_q) begin
            wrdy_q <= 1'h0;
            w_have_q <= 1'h1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else begin
            if (commit) begin
                w_have_q <= 1'h0;
            end
            wrdy_q <= ~w_have_q & ~bvalid_q;
        end
    end

    // Write response follows the commit and stands until bready.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bvalid_q <= 1'h0;
            bresp_q <= SIA_RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'h1;
            bresp_q <= wmapped ? SIA_RESP_OKAY : SIA_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channels
    // ----------------------------------------------------------------
    // Read multiplexer over the decoded word address.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_mapped = 1'h1;
        unique case ({s_axi_araddr[SIA_AW-1:2], 2'h0})
            SIA_TIMER_LATCH_OFS: rd_word[SIA_TIMERS-1:0] = timer_irq_source_latch_q;
            SIA_PIN_EN_LO_OFS: rd_word[15:0] = pin_irq_enable_q[15:0];
            SIA_PIN_EN_HI_OFS: rd_word[15:0] = pin_irq_enable_q[31:16];
            SIA_PIN_FLG_LO_OFS: rd_word[15:0] = pin_irq_flag_q[15:0];
            SIA_PIN_FLG_HI_OFS: rd_word[15:0] = pin_irq_flag_q[31:16];
            SIA_CHAN_EN_OFS: rd_word[15:0] = channel_irq_enable_reg_q;
            SIA_CHAN_FLG_OFS: rd_word[15:0] = channel_irq_flag_reg_q;
            SIA_STATUS_OFS: rd_word[6:0] = {in_isr_q, 1'h0, cpu_flag_q};
            default: rd_mapped = 1'h0;
        endcase
    end

    // Read address ready is held low while a read answer stands.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            arrdy_q <= 1'h0;
        end else if (s_axi_arvalid && arrdy_q) begin
            arrdy_q <= 1'h0;
        end else begin
            arrdy_q <= ~rvalid_q;
        end
    end

    // Read answer one cycle after the address is taken.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rvalid_q <= 1'h0;
            rdata_q <= '0;
            rresp_q <= SIA_RESP_OKAY;
        end else if (s_axi_arvalid && arrdy_q) begin
            rvalid_q <= 1'h1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? SIA_RESP_OKAY : SIA_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready = wrdy_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// ### shared/sia_pkg.sv
// Function
// - All three timer requests merge into one CPU request, shown as bit 4 of CPU flag word A.
// - Each timer expiry latches into that timer's own bit of the timer source latch.
// - A timer latch bit clears only when software writes 1 to it.
// - The shared CPU-level timer and pin flags clear by themselves on service routine entry.
// - Timers firing in the same cycle all set their latch bits together.
// - A latch bit still set at routine exit raises the timer request again; none set, quiet.
// - All pin sources merge into one CPU request, shown as bit 5 of CPU flag word B.
// - A pin acts as a source only when it is an input and its enable bit is set.
// - A per-pin flag, split over a low and a high flag register, records which of 32 pins fired.
// - Pins firing in the same cycle all set their flags together.
// - Pin flags left set after a partial clear interrupt the CPU again at routine exit.
// - All 16 DMA sources merge into one CPU request, shown as bit 8 of CPU flag word A.
// - Each DMA channel interrupt has its own enable bit in the channel enable register.
// - The interrupts of the four DMA controllers combine into one CPU request line.
// - A readable channel flag register holds one bit per DMA channel.
package sia_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int SIA_TIMERS = 3;
    localparam int SIA_PINS = 32;
    localparam int SIA_CHANS = 16;
    localparam int SIA_AW = 16;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] SIA_TIMER_LATCH_OFS = 16'h1C14;
    localparam logic [15:0] SIA_PIN_EN_LO_OFS = 16'h1C18;
    localparam logic [15:0] SIA_PIN_EN_HI_OFS = 16'h1C1C;
    localparam logic [15:0] SIA_PIN_FLG_LO_OFS = 16'h1C20;
    localparam logic [15:0] SIA_PIN_FLG_HI_OFS = 16'h1C24;
    localparam logic [15:0] SIA_CHAN_EN_OFS = 16'h1C28;
    localparam logic [15:0] SIA_CHAN_FLG_OFS = 16'h1C2C;
    localparam logic [15:0] SIA_STATUS_OFS = 16'h1C30;

    // ----------------------------------------------------------------
    // CPU flag word bit positions
    // ----------------------------------------------------------------
    localparam int SIA_TIMER_BIT = 4;
    localparam int SIA_PIN_BIT = 5;
    localparam int SIA_DMA_BIT = 8;

    // ----------------------------------------------------------------
    // Reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [15:0] SIA_REG_RST = 16'h0000;
    localparam logic [1:0] SIA_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIA_RESP_SLVERR = 2'h2;

endpackage

// ### hdl/sia_pin_sync.sv
`timescale 1ns/10ps
module sia_pin_sync
    import sia_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [SIA_PINS-1:0] pin_i,
    output logic [SIA_PINS-1:0] level_o
);

    logic [SIA_PINS-1:0] s1_q;
    logic [SIA_PINS-1:0] s2_q;
    logic [SIA_PINS-1:0] s3_q;
    logic [SIA_PINS-1:0] lvl_q;

    // Three-stage chain; only the second stage reads the first.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A pin level counts once the second and third stages agree.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    assign level_o = lvl_q;

endmodule

// ### tb/sia_sva.sv
`timescale 1ns/10ps
module sia_sva
    import sia_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [SIA_TIMERS-1:0] timer_expire_i,
    input wire logic timer_isr_enter_i,
    input wire logic timer_isr_exit_i,
    input wire logic pin_isr_enter_i,
    input wire logic dma_isr_enter_i,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_arready,
    input wire logic [15:0] cpu_flag_word_a_o,
    input wire logic [15:0] cpu_flag_word_b_o
);
    // ----
    // Timer routine tracking
    // ----
    // High between the timer entry pulse and the timer exit pulse.
    logic tsvc_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || timer_isr_exit_i) begin
            tsvc_q <= 1'h0;
        end else if (timer_isr_enter_i) begin
            tsvc_q <= 1'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ----
    // Properties
    // ----
    property p_tmr_raise;
        |timer_expire_i && !tsvc_q |-> ##2 (cpu_flag_word_a_o[4] || tsvc_q);
    endproperty
    a_tmr_raise: assert property (p_tmr_raise) else $error("timer request not raised");
    property p_tmr_enter;
        timer_isr_enter_i |=> !cpu_flag_word_a_o[4];
    endproperty
    a_tmr_enter: assert property (p_tmr_enter) else $error("timer flag kept on entry");
    property p_tmr_hold;
        tsvc_q |-> !cpu_flag_word_a_o[4];
    endproperty
    a_tmr_hold: assert property (p_tmr_hold) else $error("timer flag set in service");
    property p_tmr_fall;
        $fell(cpu_flag_word_a_o[4]) |-> $past(timer_isr_enter_i);
    endproperty
    a_tmr_fall: assert property (p_tmr_fall) else $error("timer flag fell untold");
    property p_pin_enter;
        pin_isr_enter_i |=> !cpu_flag_word_b_o[5];
    endproperty
    a_pin_enter: assert property (p_pin_enter) else $error("pin flag kept on entry");
    property p_dma_enter;
        dma_isr_enter_i |=> !cpu_flag_word_a_o[8];
    endproperty
    a_dma_enter: assert property (p_dma_enter) else $error("dma flag kept on entry");
    property p_spare;
        (cpu_flag_word_a_o & 16'hFEEF) == 16'h0000 && (cpu_flag_word_b_o & 16'hFFDF) == 16'h0000;
    endproperty
    a_spare: assert property (p_spare) else $error("flag in wrong bit");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_ar_low;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_low: assert property (p_ar_low) else $error("read taken while answering");

    // Main scenarios reached.
    c_reraise: cover property (timer_isr_exit_i ##1 cpu_flag_word_a_o[4]);
    c_multi: cover property ($countones(timer_expire_i) > 1);
    c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind sia_top sia_sva sia_sva_i (.*);

// ### tb/sia_cpu_model.sv
`timescale 1ns/10ps
module sia_cpu_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] flag_i,
    input wire logic [2:0] done_i,
    input wire logic [3:0] lat_i,
    output logic [2:0] enter_o,
    output logic [2:0] exit_o,
    output logic [2:0] insvc_o
);
    logic [3:0] wait_q [3];

    // Per group: enter after lat_i cycles of a raised flag, leave when the routine is done.
    always_ff @(posedge clk_i) begin
        for (int g = 0; g < 3; g++) begin
            enter_o[g] <= 1'h0;
            exit_o[g] <= 1'h0;
            if (sys_rst_i) begin
                insvc_o[g] <= 1'h0;
                wait_q[g] <= 4'h0;
            end else if (insvc_o[g]) begin
                if (done_i[g]) begin
                    exit_o[g] <= 1'h1;
                    insvc_o[g] <= 1'h0;
                end
            end else if (flag_i[g] && wait_q[g] >= lat_i) begin
                enter_o[g] <= 1'h1;
                insvc_o[g] <= 1'h1;
                wait_q[g] <= 4'h0;
            end else if (flag_i[g]) begin
                wait_q[g] <= wait_q[g] + 4'h1;
            end
        end
    end
endmodule

// ### tb/sia_top_tb.sv
`timescale 1ns/10ps
module sia_top_tb
    import sia_pkg::*;
;
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [SIA_TIMERS-1:0] timer_expire_i = 3'h0;
    logic [SIA_PINS-1:0] pin_i = 32'h0, pin_is_input_i = 32'h0;
    logic [SIA_CHANS-1:0] dma_chan_irq_i = 16'h0;
    logic timer_isr_enter_i, pin_isr_enter_i, dma_isr_enter_i;
    logic timer_isr_exit_i, pin_isr_exit_i, dma_isr_exit_i;
    logic [15:0] cpu_flag_word_a_o, cpu_flag_word_b_o;
    logic [2:0] enter, leave, insvc, flag;
    logic [2:0] done = 3'h0;
    logic [3:0] lat = 4'h0;
    logic [31:0] en, rise, e;
    int mismatches = 0, cmp_count = 0;

    // CPU side wiring: routine pulses in, shared flags out.
    assign {dma_isr_enter_i, pin_isr_enter_i, timer_isr_enter_i} = enter;
    assign {dma_isr_exit_i, pin_isr_exit_i, timer_isr_exit_i} = leave;
    assign flag = {cpu_flag_word_a_o[8], cpu_flag_word_b_o[5], cpu_flag_word_a_o[4]};

    sia_top sia_top_i (.*);
    sia_cpu_model sia_cpu_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .flag_i(flag),
        .done_i(done), .lat_i(lat), .enter_o(enter), .exit_o(leave), .insvc_o(insvc));

    // Clock of 4 ns.
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Lowest set bit, the flag a one-at-a-time routine serves first.
    function automatic logic [15:0] lowest(input logic [15:0] x);
        return x & (~x + 16'h1);
    endfunction

    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, x, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= {2'($urandom), 2'h3};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        repeat ($urandom_range(2)) @(posedge clk_i);
        s_axi_bready <= 1'h1;
        do @(posedge clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        repeat ($urandom_range(2)) @(posedge clk_i);
        s_axi_rready <= 1'h1;
        do @(posedge clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", x, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask

    // Waits a bounded time for the routine of group g, then compares its state.
    task automatic svc_wait(input int g, input logic x);
        for (int n = 0; n < 24 && insvc[g] !== 1'h1; n++) @(posedge clk_i);
        chk("in_service", {31'h0, x}, {31'h0, insvc[g]});
    endtask

    task automatic finish_isr(input int g);
        done[g] <= 1'h1;
        @(posedge clk_i);
        done[g] <= 1'h0;
        @(posedge clk_i);
    endtask

    // One routine clears a single flag, the next routine clears the rest.
    task automatic serve(input int g, input logic [15:0] a, input logic [15:0] x);
        logic [15:0] lo;
        lo = lowest(x);
        rd(a, {16'h0, x}, 2'h0);
        svc_wait(g, 1'h1);
        rd(SIA_STATUS_OFS, 32'h10 << g, 2'h0);
        wr(a, {16'h0, lo}, 2'h0);
        rd(a, {16'h0, x & ~lo}, 2'h0);
        finish_isr(g);
        svc_wait(g, x != lo);
        if (insvc[g]) begin
            wr(a, {16'h0, x}, 2'h0);
            rd(a, 32'h0, 2'h0);
            finish_isr(g);
            svc_wait(g, 1'h0);
        end
        chk("cpu_flag", 32'h0, {31'h0, flag[g]});
    endtask

    // Main sequence.
    initial begin
        en = $urandom(32'h273AFC8D);
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        for (int i = 0; i < 8; i++) rd(SIA_TIMER_LATCH_OFS + 16'(4 * i), 32'h0, 2'h0);
        rd(16'h1C40, 32'h0, 2'h2);
        wr(16'h1C40, 32'hFFFF, 2'h2);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            lat <= 4'($urandom_range(15));
            e = (k == 0) ? 32'h7 : 32'($urandom_range(7, 1));
            timer_expire_i <= e[2:0];
            @(posedge clk_i);
            timer_expire_i <= 3'h0;
            serve(0, SIA_TIMER_LATCH_OFS, e[15:0]);
        end
        $display("test timers done");
        for (int k = 0; k < 4; k++) begin
            en = $urandom | 32'h1;
            rise = $urandom | 32'h1;
            pin_is_input_i <= $urandom | 32'h1;
            wr(SIA_PIN_EN_LO_OFS, {16'h0, en[15:0]}, 2'h0);
            wr(SIA_PIN_EN_HI_OFS, {16'h0, en[31:16]}, 2'h0);
            e = en & pin_is_input_i & rise;
            pin_i <= rise;
            repeat (8) @(posedge clk_i);
            pin_i <= 32'h0;
            rd(SIA_PIN_FLG_HI_OFS, {16'h0, e[31:16]}, 2'h0);
            wr(SIA_PIN_FLG_HI_OFS, {16'h0, e[31:16]}, 2'h0);
            serve(1, SIA_PIN_FLG_LO_OFS, e[15:0]);
        end
        $display("test pins done");
        for (int k = 0; k < 4; k++) begin
            en = $urandom | 32'h1;
            rise = $urandom | 32'h1;
            wr(SIA_CHAN_EN_OFS, {16'h0, en[15:0]}, 2'h0);
            rd(SIA_CHAN_EN_OFS, {16'h0, en[15:0]}, 2'h0);
            dma_chan_irq_i <= rise[15:0];
            @(posedge clk_i);
            dma_chan_irq_i <= 16'h0;
            serve(2, SIA_CHAN_FLG_OFS, en[15:0] & rise[15:0]);
        end
        $display("test dma done");
        results();
    end

    // Watchdog well beyond the expected run time.
    initial begin
        #40000;
        mismatches++;
        results();
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
endmodule
